//--- rtl/snr_node_cfg.sv
// snr_node_cfg: configuration and status registers of a switch node
// assumes: mclk is the pll clock, config port and fabric on mclk,
// the shared halt line is an open-drain pin outside this clock
`timescale 1ns/1ns
`include "snr_cfg.svh"
module snr_node_cfg #(
  parameter int          N_LINK    = 9,
  parameter int          N_PROCESSOR_SIDE_PORT   = 8,
  // identity words: values are arbitrary
  parameter logic [31:0] SCAN_ID   = 32'h0000_0001,
  parameter logic [31:0] USER_CODE = 32'h0000_0000
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire logic                               cfg_wr,
  input  wire logic                               cfg_rd,
  input  wire logic [7:0]                         cfg_addr,
  input  wire logic [31:0]                        cfg_wdata,
  output logic [31:0]                             cfg_rdata,
  output logic                                    cfg_rvalid,
  output logic                                    sw_clk_tick,
  output logic                                    ref_clk_tick,
  input  wire logic [15:0]                        node_id,
  input  wire logic                               route_req,
  input  wire logic [15:0]                        route_dest_id,
  output logic                                    route_valid,
  output logic                                    route_local,
  output logic [3:0]                              route_dir,
  input  wire logic [1:0]                         halted_state_flag,
  input  wire logic                               shared_halt_line_n_i,
  output logic                                    shared_halt_line_n_o,
  output logic                                    shared_halt_line_n_oe,
  output logic [1:0]                              halt_req,
  input  snr_pkg::snr_lst_type  [N_LINK-1:0]      ext_st,
  input  snr_pkg::snr_lst_type  [N_PROCESSOR_SIDE_PORT-1:0]     processor_side_port_st,
  input  snr_pkg::snr_lev_type  [N_LINK-1:0]      ext_ev,
  output snr_pkg::snr_lctl_type [N_LINK-1:0]      ext_ctl,
  output logic [N_LINK-1:0][3:0]                  ext_dir,
  output logic [N_LINK-1:0][1:0]                  ext_net,
  output logic [N_PROCESSOR_SIDE_PORT-1:0][1:0]                 processor_side_port_net
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [15:0] sw_div;
  logic [15:0] ref_div;
  logic [15:0] sw_cnt;
  logic [15:0] ref_cnt;
  logic [31:0] dir_lo;
  logic [31:0] dir_hi;
  logic [1:0]  hcfg_req;
  logic [1:0]  hcfg_drv;
  logic [4:0]  hsrc;
  logic        pin_s1;
  logic        pin_s2;
  logic        line_prev;
  logic [N_LINK-1:0]           lc_en;
  logic [N_LINK-1:0]           lc_wide;
  logic [N_LINK-1:0][10:0]     lc_sgap;
  logic [N_LINK-1:0][10:0]     lc_tgap;
  logic [N_LINK-1:0][31:0]     lst_word;
  logic [N_PROCESSOR_SIDE_PORT-1:0][31:0]    pst_word;
  logic [N_LINK-1:0][31:0]     lcfg_word;

  // ************************************************************
  // address decode
  // ************************************************************
  wire [7:0] lst_idx  = cfg_addr - `SNR_A_LST;
  wire [7:0] pst_idx  = cfg_addr - `SNR_A_PST;
  wire [7:0] lcfg_idx = cfg_addr - `SNR_A_LCFG;
  wire       hit_lst  = (cfg_addr >= `SNR_A_LST) && (lst_idx < 8'(N_LINK));
  wire       hit_pst  = (cfg_addr >= `SNR_A_PST) && (pst_idx < 8'(N_PROCESSOR_SIDE_PORT));
  wire       hit_lcfg = (cfg_addr >= `SNR_A_LCFG) && (lcfg_idx < 8'(N_LINK));
  wire       wr_swdiv  = cfg_wr && (cfg_addr == `SNR_A_SWDIV);
  wire       wr_refdiv = cfg_wr && (cfg_addr == `SNR_A_REFDIV);
  wire       wr_dirlo  = cfg_wr && (cfg_addr == `SNR_A_DIRLO);
  wire       wr_dirhi  = cfg_wr && (cfg_addr == `SNR_A_DIRHI);
  wire       wr_hcfg0  = cfg_wr && (cfg_addr == `SNR_A_HCFG0);
  wire       wr_hcfg1  = cfg_wr && (cfg_addr == `SNR_A_HCFG1);
  wire       wr_hsrc   = cfg_wr && (cfg_addr == `SNR_A_HSRC);

  // ************************************************************
  // clock dividers
  // ************************************************************
  // count up to the divider value, then tick and wrap
  wire [15:0] next_sw_cnt  = (wr_swdiv || sw_cnt == sw_div) ? 16'h0000 : sw_cnt + 16'h0001;
  wire [15:0] next_ref_cnt = (wr_refdiv || ref_cnt == ref_div) ? 16'h0000 : ref_cnt + 16'h0001;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sw_div       <= `SNR_SWDIV_RST;
      ref_div      <= `SNR_REFDIV_RST;
      sw_cnt       <= 16'h0000;
      ref_cnt      <= 16'h0000;
      sw_clk_tick  <= 1'b0;
      ref_clk_tick <= 1'b0;
    end else begin
      if (wr_swdiv) begin
        sw_div <= cfg_wdata[15:0];
      end
      if (wr_refdiv) begin
        ref_div <= cfg_wdata[15:0];
      end
      sw_cnt       <= next_sw_cnt;
      ref_cnt      <= next_ref_cnt;
      sw_clk_tick  <= !wr_swdiv && (sw_cnt == sw_div);
      ref_clk_tick <= !wr_refdiv && (ref_cnt == ref_div);
    end
  end

  // ************************************************************
  // dimension routing
  // ************************************************************
  // most significant set bit; top bit of the result marks found
  function automatic logic [4:0] snr_msb(input logic [15:0] x);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (x[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  wire [15:0] id_diff  = node_id ^ route_dest_id;
  wire [4:0]  diff_msb = snr_msb(id_diff);
  wire [63:0] dir_tab  = {dir_hi, dir_lo};
  wire [3:0]  dir_pick = dir_tab[{diff_msb[3:0], 2'b00} +: 4];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_lo      <= 32'h0000_0000;
      dir_hi      <= 32'h0000_0000;
      route_valid <= 1'b0;
      route_local <= 1'b0;
      route_dir   <= 4'h0;
    end else begin
      if (wr_dirlo) begin
        dir_lo <= cfg_wdata;
      end
      if (wr_dirhi) begin
        dir_hi <= cfg_wdata;
      end
      route_valid <= route_req;
      if (route_req) begin
        route_local <= !diff_msb[4];
        route_dir   <= diff_msb[4] ? dir_pick : 4'h0;
      end
    end
  end

  // ************************************************************
  // shared halt line
  // ************************************************************
  wire [1:0] core_drv    = hcfg_drv & halted_state_flag;
  wire       line_active = !pin_s2;
  wire       line_event  = line_active && !line_prev;
  wire [4:0] event_src   = {!(|core_drv), 2'b00, core_drv};
  wire [4:0] src_mask    = 5'h13;

  // pin passes two flops; config, origin capture, requests
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1                <= 1'b1;
      pin_s2                <= 1'b1;
      line_prev             <= 1'b0;
      hcfg_req              <= 2'b00;
      hcfg_drv              <= 2'b00;
      hsrc                  <= 5'h00;
      halt_req              <= 2'b00;
      shared_halt_line_n_oe <= 1'b0;
    end else begin
      pin_s1    <= shared_halt_line_n_i;
      pin_s2    <= pin_s1;
      line_prev <= line_active;
      if (wr_hcfg0) begin
        hcfg_req[0] <= cfg_wdata[`SNR_HCFG_REQ];
        hcfg_drv[0] <= cfg_wdata[`SNR_HCFG_DRV];
      end
      if (wr_hcfg1) begin
        hcfg_req[1] <= cfg_wdata[`SNR_HCFG_REQ];
        hcfg_drv[1] <= cfg_wdata[`SNR_HCFG_DRV];
      end
      // a new event outranks a software write
      if (line_event) begin
        hsrc <= event_src;
      end else if (wr_hsrc) begin
        hsrc <= cfg_wdata[4:0] & src_mask;
      end
      halt_req              <= hcfg_req & {2{line_active}};
      shared_halt_line_n_oe <= |core_drv;
    end
  end

  assign shared_halt_line_n_o = 1'b0;  // open drain, pulls low only

  // ************************************************************
  // per link registers
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < N_LINK; g++) begin : g_ext
      snr_pkg::snr_lflag_type fl;
      wire wr_lst  = cfg_wr && hit_lst && (lst_idx == 8'(g));
      wire wr_lcfg = cfg_wr && hit_lcfg && (lcfg_idx == 8'(g));

      // writable direction, network and link configuration
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          ext_dir[g] <= 4'h0;
          ext_net[g] <= 2'b00;
          lc_en[g]   <= 1'b0;
          lc_wide[g] <= 1'b0;
          lc_sgap[g] <= 11'h000;
          lc_tgap[g] <= 11'h000;
        end else begin
          if (wr_lst) begin
            ext_dir[g] <= cfg_wdata[`SNR_LS_DIR +: 4];
            ext_net[g] <= cfg_wdata[`SNR_LS_NET +: 2];
          end
          if (wr_lcfg) begin
            lc_en[g]   <= cfg_wdata[`SNR_LC_EN];
            lc_wide[g] <= cfg_wdata[`SNR_LC_WIDE];
            lc_sgap[g] <= cfg_wdata[`SNR_LC_SGAP +: 11];
            lc_tgap[g] <= cfg_wdata[`SNR_LC_TGAP +: 11];
          end
        end
      end

      snr_link #(
        .GAP_W (`SNR_GAP_W)
      ) u_link (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (lc_en[g]),
        .greet    (wr_lcfg && cfg_wdata[`SNR_LC_GREET]),
        .rx_rst   (wr_lcfg && cfg_wdata[`SNR_LC_RXRST]),
        .sym_gap  (lc_sgap[g]),
        .tok_gap  (lc_tgap[g]),
        .ev       (ext_ev[g]),
        .flags    (fl),
        .greet_tx (ext_ctl[g].greet_tx),
        .rx_reset (ext_ctl[g].rx_reset),
        .sym_ok   (ext_ctl[g].sym_ok)
      );

      assign ext_ctl[g].enable = lc_en[g];
      assign ext_ctl[g].wide   = lc_wide[g];

      // read words; write-only and reserved bits read zero
      assign lst_word[g] = {6'h00, ext_st[g].source_kind, ext_st[g].dest_link,
                            4'h0, ext_dir[g], 2'b00, ext_net[g], 1'b0,
                            ext_st[g].junk, ext_st[g].dest_busy, ext_st[g].src_busy};
      assign lcfg_word[g] = {lc_en[g], lc_wide[g], 2'b00, fl.err, fl.cr_issued,
                             fl.cr_held, 3'b000, lc_sgap[g], lc_tgap[g]};
    end

    for (g = 0; g < N_PROCESSOR_SIDE_PORT; g++) begin : g_proc
      wire wr_pst = cfg_wr && hit_pst && (pst_idx == 8'(g));

      // processor link network number
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          processor_side_port_net[g] <= 2'b00;
        end else if (wr_pst) begin
          processor_side_port_net[g] <= cfg_wdata[`SNR_LS_NET +: 2];
        end
      end

      assign pst_word[g] = {6'h00, processor_side_port_st[g].source_kind, processor_side_port_st[g].dest_link,
                            10'h000, processor_side_port_net[g], 1'b0,
                            processor_side_port_st[g].junk, processor_side_port_st[g].dest_busy, processor_side_port_st[g].src_busy};
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************
  wire [31:0] rd_word =
    (cfg_addr == `SNR_A_SWDIV)  ? {16'h0000, sw_div} :
    (cfg_addr == `SNR_A_REFDIV) ? {16'h0000, ref_div} :
    (cfg_addr == `SNR_A_SCANID) ? SCAN_ID :
    (cfg_addr == `SNR_A_UCODE)  ? USER_CODE :
    (cfg_addr == `SNR_A_DIRLO)  ? dir_lo :
    (cfg_addr == `SNR_A_DIRHI)  ? dir_hi :
    (cfg_addr == `SNR_A_HCFG0)  ? {30'h0, hcfg_req[0], hcfg_drv[0]} :
    (cfg_addr == `SNR_A_HCFG1)  ? {30'h0, hcfg_req[1], hcfg_drv[1]} :
    (cfg_addr == `SNR_A_HSRC)   ? {27'h0, hsrc} :
    hit_lst  ? lst_word[lst_idx[3:0]] :
    hit_pst  ? pst_word[pst_idx[2:0]] :
    hit_lcfg ? lcfg_word[lcfg_idx[3:0]] :
    32'h0000_0000;

  // read data one cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rd_word;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_sw_tick;
    @(posedge mclk) disable iff (!rst_n)
    (sw_clk_tick && sw_div == 16'h0002 && !cfg_wr) |=> !sw_clk_tick;
  endproperty
  a_sw_tick: assert property (p_sw_tick) else $error("switch tick too early");

  property p_route_top;
    @(posedge mclk) disable iff (!rst_n)
    (route_req && id_diff[15] && !wr_dirhi) |=> (route_valid && route_dir == dir_hi[31:28]);
  endproperty
  a_route_top: assert property (p_route_top) else $error("top dimension misrouted");

  property p_route_low;
    @(posedge mclk) disable iff (!rst_n)
    (route_req && id_diff == 16'h0001 && !wr_dirlo) |=> (!route_local && route_dir == dir_lo[3:0]);
  endproperty
  a_route_low: assert property (p_route_low) else $error("dimension zero misrouted");

  property p_route_local;
    @(posedge mclk) disable iff (!rst_n)
    (route_req && id_diff == 16'h0000) |=> route_local;
  endproperty
  a_route_local: assert property (p_route_local) else $error("local packet not seen");

  property p_dir_write;
    @(posedge mclk) disable iff (!rst_n)
    (cfg_wr && cfg_addr == `SNR_A_LST) |=> (ext_dir[0] == $past(cfg_wdata[11:8]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("link direction not stored");

  property p_line_drive;
    @(posedge mclk) disable iff (!rst_n)
    (|(hcfg_drv & halted_state_flag)) |=> shared_halt_line_n_oe;
  endproperty
  a_line_drive: assert property (p_line_drive) else $error("halt line not driven");

  property p_halt_req;
    @(posedge mclk) disable iff (!rst_n)
    halt_req[0] |-> ($past(hcfg_req[0]) && $past(line_active));
  endproperty
  a_halt_req: assert property (p_halt_req) else $error("request without enable");

  property p_pin_origin;
    @(posedge mclk) disable iff (!rst_n)
    (line_event && core_drv == 2'b00) |=> (hsrc == 5'h10);
  endproperty
  a_pin_origin: assert property (p_pin_origin) else $error("pin origin not recorded");

  property p_stat_read;
    @(posedge mclk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == `SNR_A_LST) |=>
      (cfg_rvalid && cfg_rdata[2:0] == $past({ext_st[0].junk, ext_st[0].dest_busy, ext_st[0].src_busy}));
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("link status read wrong");

  c_route: cover property (@(posedge mclk) disable iff (!rst_n) route_req && id_diff[9]);
  c_halt: cover property (@(posedge mclk) disable iff (!rst_n) line_event ##2 |halt_req);
  c_enable: cover property (@(posedge mclk) disable iff (!rst_n) cfg_wr && hit_lcfg && cfg_wdata[31]);
endmodule

//--- rtl/snr_cfg.svh
// snr_cfg.svh: register numbers, field positions, reset values
// assumes: included by every design module
// Operation
// - switch clock divider, 16 bits, resets zero
// - reference clock divider, 16 bits, resets three
// - route by most significant differing id bit
// - low table, dimensions 0..7, nibbles, reset zero
// - high table, dimensions 8..15, nibbles, reset zero
// - per tile, halt line raises core request
// - per tile, halted flag drives halt line
// - halt origin flags: pin, core one, zero
// - link status shows 2-bit source kind
// - link status shows destination link number
// - external link writable 4-bit direction, reset zero
// - every link writable 2-bit network, reset zero
// - read-only junk, dest busy, source busy flags
// - processor links same fields, no direction
// - top config bit enables link, selects pins
// - width bit: zero two-wire, one five-wire
// - error flag on overflow or bad token
// - credit issued and credit held flags
// - greeting write clears credit, sends token
// - receiver reset write restarts token framing
// - symbol gap field, idle clocks minus one
// - token gap field, idle clocks minus one
`ifndef SNR_CFG_SVH
`define SNR_CFG_SVH
`define SNR_A_SWDIV    8'h07
`define SNR_A_REFDIV   8'h08
`define SNR_A_SCANID   8'h09
`define SNR_A_UCODE    8'h0a
`define SNR_A_DIRLO    8'h0c
`define SNR_A_DIRHI    8'h0d
`define SNR_A_HCFG0    8'h10
`define SNR_A_HCFG1    8'h11
`define SNR_A_HSRC     8'h1f
`define SNR_A_LST      8'h20
`define SNR_A_PST      8'h40
`define SNR_A_LCFG     8'h80
`define SNR_SWDIV_RST  16'h0000
`define SNR_REFDIV_RST 16'h0003
`define SNR_HCFG_DRV   0
`define SNR_HCFG_REQ   1
`define SNR_HSRC_PIN   4
`define SNR_LC_EN      31
`define SNR_LC_WIDE    30
`define SNR_LC_ERR     27
`define SNR_LC_CRI     26
`define SNR_LC_CRH     25
`define SNR_LC_GREET   24
`define SNR_LC_RXRST   23
`define SNR_LC_SGAP    11
`define SNR_LC_TGAP    0
`define SNR_LS_KIND    24
`define SNR_LS_DEST    16
`define SNR_LS_DIR     8
`define SNR_LS_NET     4
`define SNR_GAP_W      11
`endif

//--- rtl/snr_pkg.sv
// snr_pkg: carrier types of the switch node configuration block
// assumes: constants live in snr_cfg.svh
package snr_pkg;
  // kind of source target behind a link
  typedef enum logic [1:0] {
    snr_switch_side_port    = 2'b00,
    snr_processor_side_port = 2'b01,
    snr_switch_control      = 2'b10,
    snr_undefined           = 2'b11
  } snr_kind_type;

  // live link state from the switch fabric
  typedef struct packed {
    snr_kind_type source_kind;
    logic [7:0]   dest_link;
    logic         junk;
    logic         dest_busy;
    logic         src_busy;
  } snr_lst_type;

  // one-cycle events from an external link front end
  typedef struct packed {
    logic rx_overflow;
    logic rx_bad_token;
    logic credit_issued;
    logic credit_granted;
    logic sym_sent;
    logic tok_end;
  } snr_lev_type;

  // controls toward an external link front end
  typedef struct packed {
    logic enable;
    logic wide;
    logic greet_tx;
    logic rx_reset;
    logic sym_ok;
  } snr_lctl_type;

  // read-only link flags
  typedef struct packed {
    logic err;
    logic cr_issued;
    logic cr_held;
  } snr_lflag_type;
endpackage

//--- rtl/snr_link.sv
// snr_link: credit, error and symbol pacing for one external link
// assumes: events come from logic on mclk, one cycle each
`timescale 1ns/1ns
`include "snr_cfg.svh"
module snr_link #(
  parameter int GAP_W = `SNR_GAP_W
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  enable,
  input  wire logic                  greet,
  input  wire logic                  rx_rst,
  input  wire logic [GAP_W-1:0]      sym_gap,
  input  wire logic [GAP_W-1:0]      tok_gap,
  input  snr_pkg::snr_lev_type       ev,
  output snr_pkg::snr_lflag_type     flags,
  output logic                       greet_tx,
  output logic                       rx_reset,
  output logic                       sym_ok
);
  logic [GAP_W:0] gap_cnt;
  logic [GAP_W:0] next_gap;

  // idle gap reload: a token end outranks a plain symbol
  assign next_gap = ev.tok_end ? ({1'b0, tok_gap} + 1'b1) :
                    ev.sym_sent ? ({1'b0, sym_gap} + 1'b1) :
                    (gap_cnt == '0) ? gap_cnt : (gap_cnt - 1'b1);
  assign sym_ok = enable && (gap_cnt == '0);

  // flags: hardware set wins over any clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gap_cnt  <= '0;
      greet_tx <= 1'b0;
      rx_reset <= 1'b0;
      flags    <= '0;
    end else begin
      gap_cnt         <= next_gap;
      greet_tx        <= greet && enable;
      rx_reset        <= rx_rst;
      flags.err       <= ev.rx_overflow || ev.rx_bad_token || (flags.err && !rx_rst);
      flags.cr_issued <= ev.credit_issued || (flags.cr_issued && enable);
      flags.cr_held   <= ev.credit_granted || (flags.cr_held && enable && !greet);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_greet_clears;
    @(posedge mclk) disable iff (!rst_n)
    (greet && enable && !ev.credit_granted) |=> (greet_tx && !flags.cr_held);
  endproperty
  a_greet_clears: assert property (p_greet_clears) else $error("greeting did not clear credit");

  property p_rx_reset;
    @(posedge mclk) disable iff (!rst_n)
    rx_rst |=> (rx_reset ##1 !rx_reset || $past(rx_rst, 1));
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver reset pulse wrong");

  property p_tok_gap;
    @(posedge mclk) disable iff (!rst_n)
    (ev.tok_end && enable) |=>
      (!sym_ok ##1 (sym_ok || !enable || tok_gap != '0 || $past(ev.tok_end || ev.sym_sent)));
  endproperty
  a_tok_gap: assert property (p_tok_gap) else $error("token gap not kept");

  property p_err_set;
    @(posedge mclk) disable iff (!rst_n)
    (ev.rx_overflow || ev.rx_bad_token) |=> flags.err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag missed");

  c_greet: cover property (@(posedge mclk) disable iff (!rst_n) greet && enable ##1 greet_tx);
endmodule

//--- test/snr_peer.sv
// snr_peer: far switch node on external link 0
// assumes: shares mclk with the block, events last one cycle
`timescale 1ns/1ns
module snr_peer (
  input  wire logic            mclk,
  input  wire logic            en,
  input  wire logic            greet,
  input  wire logic            bad_tok,
  output snr_pkg::snr_lev_type ev
);
  logic [3:0] wait_cnt = 4'h0;
  initial ev = '0;
  // answer a greeting with credit a few cycles later
  always @(posedge mclk) begin
    ev <= '0;
    if (greet && en) begin
      wait_cnt <= 4'h5;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
    ev.credit_granted <= (wait_cnt == 4'h1);
    ev.rx_bad_token   <= bad_tok; // commanded bad token
    ev.tok_end        <= (wait_cnt == 4'h3); // a token ends while credit is pending
  end
endmodule

//--- test/testbench.sv
// testbench: drives the switch node config block, checks reads and routes
// assumes: peer model drives link 0 events, other links idle
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, route_req = 1'b0, pin_low = 1'b0, bad_tok = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, dir_lo, dir_hi;
  logic [15:0] node_id = 16'h0, route_dest_id = 16'h0, dest;
  logic [1:0]  hflag = 2'h0, hreq;
  logic [3:0]  route_dir;
  logic        rvalid, route_valid, route_local, oe, line_o, sw_tick, ref_tick;
  logic [31:0] n_sw = 32'h0, n_ref = 32'h0;
  snr_pkg::snr_lst_type [8:0]  ext_st = '0;
  snr_pkg::snr_lst_type [7:0]  processor_side_port_st = '0;
  snr_pkg::snr_lev_type        peer_ev;
  snr_pkg::snr_lctl_type [8:0] ext_ctl;
  logic [31:0] exp_q[$];
  int          bad_count = 0, compares = 0;
  initial forever #4 mclk = ~mclk;
  snr_node_cfg i_dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(rvalid), .sw_clk_tick(sw_tick),
    .ref_clk_tick(ref_tick),
    .node_id(node_id), .route_req(route_req), .route_dest_id(route_dest_id), .route_valid(route_valid),
    .route_local(route_local), .route_dir(route_dir), .halted_state_flag(hflag),
    .shared_halt_line_n_i(!(oe || pin_low)), .shared_halt_line_n_o(line_o), .shared_halt_line_n_oe(oe),
    .halt_req(hreq), .ext_st(ext_st), .processor_side_port_st(processor_side_port_st), .ext_ev({48'h0, peer_ev}), .ext_ctl(ext_ctl),
    .ext_dir(), .ext_net(), .processor_side_port_net());
  snr_peer i_peer (.mclk(mclk), .en(ext_ctl[0].enable), .greet(ext_ctl[0].greet_tx), .bad_tok(bad_tok), .ev(peer_ev));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic print_verdict();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic route(input logic [15:0] d, input logic [31:0] e);
    exp_q.push_back(e);
    route_req <= 1'b1;
    route_dest_id <= d;
    @(posedge mclk);
    route_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // oldest note against each answer
  always @(negedge mclk) begin
    if (rvalid || route_valid) begin
      chk(rvalid ? cfg_rdata : {27'h0, route_local, route_dir}, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(63369));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    node_id <= 16'($urandom());
    ext_st[0] <= snr_pkg::snr_lst_type'(13'($urandom()));
    processor_side_port_st[0] <= snr_pkg::snr_lst_type'(13'($urandom()));
    @(posedge mclk);
    rd(8'h07, 32'h0);
    rd(8'h08, 32'h3);
    wr(8'h09, 32'hffffffff);
    rd(8'h09, 32'h1);
    rd(8'h30, 32'h0);
    wr(8'h07, 32'hffffffff);
    rd(8'h07, 32'h0000ffff);
    // divider n ticks every n+1 cycles: 60 cycles give 20 and 15 ticks
    wr(8'h07, 32'h2);
    repeat (60) begin
      @(posedge mclk);
      #1;
      n_sw = n_sw + sw_tick;
      n_ref = n_ref + ref_tick;
    end
    chk(n_sw, 32'h14);
    chk(n_ref, 32'hf);
    dir_lo = $urandom();
    dir_hi = $urandom();
    wr(8'h0c, dir_lo);
    wr(8'h0d, dir_hi);
    rd(8'h0c, dir_lo);
    rd(8'h0d, dir_hi);
    for (int k = 0; k < 16; k++) begin
      dest = node_id ^ (16'h1 << k) ^ (16'($urandom()) & ((16'h1 << k) - 16'h1));
      route(dest, {28'h0, (k < 8) ? dir_lo[4*k +: 4] : dir_hi[4*(k-8) +: 4]});
    end
    route(node_id, 32'h10);
    wr(8'h20, 32'hffffffff);
    wr(8'h40, 32'hffffffff);
    rd(8'h20, {6'h0, ext_st[0][12:3], 8'h0f, 4'h3, 1'b0, ext_st[0][2:0]});
    rd(8'h40, {6'h0, processor_side_port_st[0][12:3], 10'h0, 2'h3, 1'b0, processor_side_port_st[0][2:0]});
    for (int k = 0; k < 4; k++) begin
      ext_st[8] <= snr_pkg::snr_lst_type'({k[1:0], 11'h0});
      rd(8'h28, {6'h0, k[1:0], 24'h0});
    end
    wr(8'h80, 32'hc03ff805);
    rd(8'h80, 32'hc03ff805);
    wr(8'h80, 32'hc13ff805);
    repeat (8) @(posedge mclk);
    rd(8'h80, 32'hc23ff805);
    bad_tok <= 1'b1;
    @(posedge mclk);
    bad_tok <= 1'b0;
    @(posedge mclk);
    rd(8'h80, 32'hca3ff805);
    wr(8'h80, 32'hc0bff805);
    rd(8'h80, 32'hc23ff805);
    wr(8'h80, 32'h0);
    rd(8'h80, 32'h0);
    wr(8'h10, 32'h3);
    hflag <= 2'b11;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, oe}, 32'h1);
    chk({31'h0, line_o}, 32'h0);
    chk({30'h0, hreq}, 32'h1);
    @(posedge mclk);
    rd(8'h1f, 32'h1);
    hflag <= 2'b00;
    wr(8'h1f, 32'h0);
    repeat (4) @(posedge mclk);
    pin_low <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(8'h1f, 32'h10);
    pin_low <= 1'b0;
    print_verdict();
  end
endmodule
